//--- core/fcd_cfg.svh
// constants of the flash command sequencer: addresses, command codes, bus timing
`ifndef FCD_CFG_SVH
`define FCD_CFG_SVH

`define FCD_CLK_MHZ      200
`define FCD_T_SETUP_NS   5
`define FCD_T_WP_NS      35
`define FCD_T_WPH_NS     20
`define FCD_T_ACC_NS     100

`define FCD_A_ANY        11'h000
`define FCD_A_UNLOCK1    11'h555
`define FCD_A_UNLOCK2    11'h2aa

`define FCD_D_UNLOCK1    8'haa
`define FCD_D_UNLOCK2    8'h55
`define FCD_D_RESET      8'hf0
`define FCD_D_SR_READ    8'h70
`define FCD_D_SR_CLEAR   8'h71
`define FCD_D_PROG       8'ha0
`define FCD_D_BUF_LOAD   8'h25
`define FCD_D_BUF_CONF   8'h29
`define FCD_D_ERASE      8'h80
`define FCD_D_CHIP_ER    8'h10
`define FCD_D_SECT_ER    8'h30
`define FCD_D_SUSPEND    8'hb0
`define FCD_D_RESUME     8'h30
`define FCD_D_VPB_SET    8'h00
`define FCD_D_VPB_CLR    8'h01

`endif

//--- core/fcd_host.sv
// host-side sequencer that issues flash command cycles on the asynchronous x16 bus
`timescale 1ns/10ps
`include "fcd_cfg.svh"
// What this block does
// - one write of F0 anywhere returns the device to array read
// - status read: write 70 to 555, then one read returns status
// - one write of 71 to 555 clears status error bits
// - word program: AA@555, 55@2AA, A0@555, then data at target word
// - buffer program: unlock pair, 25@sector, count@sector, then location/data pairs
// - buffer abort recovery: AA@555, 55@2AA, F0@555 returns to read mode
// - chip erase: unlock, 80@555, unlock, 10@555; erase starts after last write
// - sector erase: as chip erase but sixth write is 30 inside sector
// - suspend: single write of B0 anywhere pauses embedded erase or program
// - resume: single write of 30 anywhere continues suspended operation
// - in volatile protection overlay, A0 then 00/01 at sector sets/clears bit
module fcd_host #(
   parameter int ADDR_W = 26
) (
   input  wire logic                ref_clk,
   input  wire logic                arst_n,
   input  wire logic                cmd_valid,
   input  wire fcd_pkg::fcd_op_e    cmd_op,
   input  wire logic [ADDR_W-1:0]   cmd_addr,
   input  wire logic [15:0]         cmd_data,
   input  wire logic [7:0]          cmd_count,
   output logic                     cmd_ready,
   output logic                     cmd_done,
   input  wire logic                buf_valid,
   input  wire logic [ADDR_W-1:0]   buf_loc,
   input  wire logic [15:0]         buf_data,
   output logic                     buf_ready,
   output logic [15:0]              rd_data,
   output logic                     rd_valid,
   output logic [ADDR_W-1:0]        fl_addr,
   output logic [15:0]              fl_dq_out,
   output logic                     fl_dq_oe,
   input  wire logic [15:0]         fl_dq_in,
   output logic                     fl_ce_n,
   output logic                     fl_we_n,
   output logic                     fl_oe_n
);

   ////////////////////////////////////////////////////////////////////////////////
   // timing counts, rounded up to whole cycles
   localparam int SETUP_CYC = (`FCD_T_SETUP_NS * `FCD_CLK_MHZ + 999) / 1000;
   localparam int WP_CYC    = (`FCD_T_WP_NS * `FCD_CLK_MHZ + 999) / 1000;
   localparam int WPH_CYC   = (`FCD_T_WPH_NS * `FCD_CLK_MHZ + 999) / 1000;
   localparam int ACC_CYC   = (`FCD_T_ACC_NS * `FCD_CLK_MHZ + 999) / 1000;

   if (ADDR_W < 11 || ADDR_W > 32) begin : g_bad_addr_w
      $error("ADDR_W must lie between 11 and 32");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sequence table
   function automatic fcd_pkg::fcd_step_s mk(input fcd_pkg::fcd_kind_e k, input logic ua,
                                             input fcd_pkg::fcd_dsel_e ds,
                                             input logic [10:0] a, input logic [7:0] d);
      return '{kind: k, user_addr: ua, dsel: ds, addr: a, data: d};
   endfunction
   function automatic fcd_pkg::fcd_step_s wr(input logic [10:0] a, input logic [7:0] d);
      return mk(fcd_pkg::FCD_K_WR, 1'b0, fcd_pkg::FCD_DS_CONST, a, d);
   endfunction
   function automatic fcd_pkg::fcd_step_s wr_sect(input logic [7:0] d);
      return mk(fcd_pkg::FCD_K_WR, 1'b1, fcd_pkg::FCD_DS_CONST, `FCD_A_ANY, d);
   endfunction

   function automatic fcd_pkg::fcd_step_s step_of(input fcd_pkg::fcd_op_e op,
                                                  input logic [2:0] n);
      fcd_pkg::fcd_step_s fin, u1, u2, s;
      fin = mk(fcd_pkg::FCD_K_END, 1'b0, fcd_pkg::FCD_DS_CONST, `FCD_A_ANY, 8'h00);
      u1  = wr(`FCD_A_UNLOCK1, `FCD_D_UNLOCK1);
      u2  = wr(`FCD_A_UNLOCK2, `FCD_D_UNLOCK2);
      s   = fin;
      case (op)
         fcd_pkg::FCD_OP_READ: begin
            if (n == 3'd0) s = mk(fcd_pkg::FCD_K_RD, 1'b1, fcd_pkg::FCD_DS_CONST, `FCD_A_ANY, 8'h00);
         end
         fcd_pkg::FCD_OP_RESET: if (n == 3'd0) s = wr(`FCD_A_ANY, `FCD_D_RESET);
         fcd_pkg::FCD_OP_SR_READ: begin
            case (n)
               3'd0:    s = wr(`FCD_A_UNLOCK1, `FCD_D_SR_READ);
               3'd1:    s = mk(fcd_pkg::FCD_K_RD, 1'b1, fcd_pkg::FCD_DS_CONST, `FCD_A_ANY, 8'h00);
               default: s = fin;
            endcase
         end
         fcd_pkg::FCD_OP_SR_CLEAR: begin
            if (n == 3'd0) s = wr(`FCD_A_UNLOCK1, `FCD_D_SR_CLEAR);
         end
         fcd_pkg::FCD_OP_WORD_PROG: begin
            case (n)
               3'd0:    s = u1;
               3'd1:    s = u2;
               3'd2:    s = wr(`FCD_A_UNLOCK1, `FCD_D_PROG);
               3'd3:    s = mk(fcd_pkg::FCD_K_WR, 1'b1, fcd_pkg::FCD_DS_USER, `FCD_A_ANY, 8'h00);
               default: s = fin;
            endcase
         end
         fcd_pkg::FCD_OP_BUF_PROG: begin
            case (n)
               3'd0:    s = u1;
               3'd1:    s = u2;
               3'd2:    s = wr_sect(`FCD_D_BUF_LOAD);
               3'd3:    s = mk(fcd_pkg::FCD_K_WR, 1'b1, fcd_pkg::FCD_DS_COUNT, `FCD_A_ANY, 8'h00);
               3'd4:    s = mk(fcd_pkg::FCD_K_LOAD, 1'b0, fcd_pkg::FCD_DS_CONST, `FCD_A_ANY, 8'h00);
               3'd5:    s = wr_sect(`FCD_D_BUF_CONF);
               default: s = fin;
            endcase
         end
         fcd_pkg::FCD_OP_BUF_ABORT: begin
            case (n)
               3'd0:    s = u1;
               3'd1:    s = u2;
               3'd2:    s = wr(`FCD_A_UNLOCK1, `FCD_D_RESET);
               default: s = fin;
            endcase
         end
         fcd_pkg::FCD_OP_CHIP_ERASE, fcd_pkg::FCD_OP_SECT_ERASE: begin
            case (n)
               3'd0, 3'd3: s = u1;
               3'd1, 3'd4: s = u2;
               3'd2:       s = wr(`FCD_A_UNLOCK1, `FCD_D_ERASE);
               3'd5:       s = (op == fcd_pkg::FCD_OP_CHIP_ERASE) ?
                                  wr(`FCD_A_UNLOCK1, `FCD_D_CHIP_ER) :
                                  wr_sect(`FCD_D_SECT_ER);
               default:    s = fin;
            endcase
         end
         fcd_pkg::FCD_OP_SUSPEND: if (n == 3'd0) s = wr(`FCD_A_ANY, `FCD_D_SUSPEND);
         fcd_pkg::FCD_OP_RESUME: if (n == 3'd0) s = wr(`FCD_A_ANY, `FCD_D_RESUME);
         fcd_pkg::FCD_OP_VPB_SET, fcd_pkg::FCD_OP_VPB_CLR: begin
            case (n)
               3'd0:    s = wr(`FCD_A_ANY, `FCD_D_PROG);
               3'd1:    s = wr_sect((op == fcd_pkg::FCD_OP_VPB_SET) ? `FCD_D_VPB_SET
                                                                     : `FCD_D_VPB_CLR);
               default: s = fin;
            endcase
         end
         default: s = fin;
      endcase
      return s;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // state
   fcd_pkg::fcd_state_e state_q;
   fcd_pkg::fcd_op_e    op_q;
   logic [ADDR_W-1:0]   addr_q;
   logic [15:0]         data_q;
   logic [7:0]          count_q;
   logic [8:0]          rem_q;
   logic [2:0]          step_q;
   logic [7:0]          cnt_q;

   fcd_pkg::fcd_step_s  cur;
   logic [ADDR_W-1:0]   step_addr;
   logic [15:0]         step_data;
   logic                load_done;

   assign cur       = step_of(op_q, step_q);
   assign step_addr = cur.user_addr ? addr_q : ADDR_W'(cur.addr);
   assign step_data = (cur.dsel == fcd_pkg::FCD_DS_USER)  ? data_q :
                      (cur.dsel == fcd_pkg::FCD_DS_COUNT) ? {8'h00, count_q} :
                                                            {8'h00, cur.data};
   // the load step ends after the last location/data pair
   assign load_done = (cur.kind != fcd_pkg::FCD_K_LOAD) || (rem_q == 9'h000);

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q   <= fcd_pkg::FCD_S_IDLE;
         op_q      <= fcd_pkg::FCD_OP_READ;
         addr_q    <= '0;
         data_q    <= 16'h0000;
         count_q   <= 8'h00;
         rem_q     <= 9'h000;
         step_q    <= 3'h0;
         cnt_q     <= 8'h00;
         cmd_ready <= 1'b0;
         cmd_done  <= 1'b0;
         buf_ready <= 1'b0;
         rd_data   <= 16'h0000;
         rd_valid  <= 1'b0;
         fl_addr   <= '0;
         fl_dq_out <= 16'h0000;
         fl_dq_oe  <= 1'b0;
         fl_ce_n   <= 1'b1;
         fl_we_n   <= 1'b1;
         fl_oe_n   <= 1'b1;
      end else begin
         cmd_done  <= 1'b0;
         buf_ready <= 1'b0;
         rd_valid  <= 1'b0;
         case (state_q)
            fcd_pkg::FCD_S_IDLE: begin
               cmd_ready <= 1'b1;
               if (cmd_valid && cmd_ready) begin
                  cmd_ready <= 1'b0;
                  op_q      <= cmd_op;
                  addr_q    <= cmd_addr;
                  data_q    <= cmd_data;
                  count_q   <= cmd_count;
                  rem_q     <= {1'b0, cmd_count} + 9'h001;
                  step_q    <= 3'h0;
                  state_q   <= fcd_pkg::FCD_S_FETCH;
               end
            end
            fcd_pkg::FCD_S_FETCH: begin
               cnt_q <= 8'(SETUP_CYC - 1);
               case (cur.kind)
                  fcd_pkg::FCD_K_WR: begin
                     fl_addr   <= step_addr;
                     fl_dq_out <= step_data;
                     fl_dq_oe  <= 1'b1;
                     fl_ce_n   <= 1'b0;
                     state_q   <= fcd_pkg::FCD_S_SETUP;
                  end
                  fcd_pkg::FCD_K_RD: begin
                     fl_addr <= step_addr;
                     fl_ce_n <= 1'b0;
                     fl_oe_n <= 1'b0;
                     cnt_q   <= 8'(ACC_CYC - 1);
                     state_q <= fcd_pkg::FCD_S_RWAIT;
                  end
                  fcd_pkg::FCD_K_LOAD: begin
                     if (buf_valid) begin
                        buf_ready <= 1'b1;
                        rem_q     <= rem_q - 9'h001;
                        fl_addr   <= buf_loc;
                        fl_dq_out <= buf_data;
                        fl_dq_oe  <= 1'b1;
                        fl_ce_n   <= 1'b0;
                        state_q   <= fcd_pkg::FCD_S_SETUP;
                     end
                  end
                  default: begin
                     cmd_done <= 1'b1;
                     state_q  <= fcd_pkg::FCD_S_IDLE;
                  end
               endcase
            end
            fcd_pkg::FCD_S_SETUP: begin
               if (cnt_q == 8'h00) begin
                  fl_we_n <= 1'b0;
                  cnt_q   <= 8'(WP_CYC - 1);
                  state_q <= fcd_pkg::FCD_S_PULSE;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            fcd_pkg::FCD_S_PULSE: begin
               if (cnt_q == 8'h00) begin
                  fl_we_n <= 1'b1;
                  cnt_q   <= 8'(WPH_CYC - 1);
                  state_q <= fcd_pkg::FCD_S_RECOV;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            fcd_pkg::FCD_S_RWAIT: begin
               if (cnt_q == 8'h00) begin
                  rd_data  <= fl_dq_in;
                  rd_valid <= 1'b1;
                  fl_oe_n  <= 1'b1;
                  cnt_q    <= 8'(WPH_CYC - 1);
                  state_q  <= fcd_pkg::FCD_S_RECOV;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            fcd_pkg::FCD_S_RECOV: begin
               fl_dq_oe <= 1'b0;
               fl_ce_n  <= 1'b1;
               if (cnt_q == 8'h00) begin
                  if (load_done) step_q <= step_q + 3'h1;
                  state_q <= fcd_pkg::FCD_S_FETCH;
               end else begin
                  cnt_q <= cnt_q - 8'h01;
               end
            end
            default: state_q <= fcd_pkg::FCD_S_IDLE;
         endcase
      end
   end

endmodule // fcd_host

//--- core/fcd_pkg.sv
// types of the flash command sequencer
package fcd_pkg;

   typedef enum logic [3:0] {
      FCD_OP_READ       = 4'b0000,
      FCD_OP_RESET      = 4'b0001,
      FCD_OP_SR_READ    = 4'b0010,
      FCD_OP_SR_CLEAR   = 4'b0011,
      FCD_OP_WORD_PROG  = 4'b0100,
      FCD_OP_BUF_PROG   = 4'b0101,
      FCD_OP_BUF_ABORT  = 4'b0110,
      FCD_OP_CHIP_ERASE = 4'b0111,
      FCD_OP_SECT_ERASE = 4'b1000,
      FCD_OP_SUSPEND    = 4'b1001,
      FCD_OP_RESUME     = 4'b1010,
      FCD_OP_VPB_SET    = 4'b1011,
      FCD_OP_VPB_CLR    = 4'b1100
   } fcd_op_e;

   typedef enum logic [1:0] {
      FCD_K_END  = 2'b00,
      FCD_K_WR   = 2'b01,
      FCD_K_RD   = 2'b10,
      FCD_K_LOAD = 2'b11
   } fcd_kind_e;

   typedef enum logic [1:0] {
      FCD_DS_CONST = 2'b00,
      FCD_DS_USER  = 2'b01,
      FCD_DS_COUNT = 2'b10
   } fcd_dsel_e;

   typedef enum logic [2:0] {
      FCD_S_IDLE  = 3'b000,
      FCD_S_FETCH = 3'b001,
      FCD_S_SETUP = 3'b010,
      FCD_S_PULSE = 3'b011,
      FCD_S_RECOV = 3'b100,
      FCD_S_RWAIT = 3'b101
   } fcd_state_e;

   typedef struct packed {
      fcd_kind_e   kind;
      logic        user_addr;
      fcd_dsel_e   dsel;
      logic [10:0] addr;
      logic [7:0]  data;
   } fcd_step_s;

endpackage

//--- tb/fcd_flash_model.sv
// behavioural flash device on the far side of the sequencer
`timescale 1ns/10ps
`include "fcd_cfg.svh"
module fcd_flash_model #(
   parameter int ADDR_W = 26
) (
   input  wire logic [ADDR_W-1:0] fl_addr,
   input  wire logic [15:0]       fl_dq_out,
   input  wire logic              fl_dq_oe,
   output logic [15:0]            fl_dq_in,
   input  wire logic              fl_ce_n,
   input  wire logic              fl_we_n,
   input  wire logic              fl_oe_n
);
   logic [ADDR_W-1:0] wa [0:63];
   logic [15:0]       wd [0:63];
   int                n_wr = 0;
   logic [15:0]       sr_q = 16'h00a0;
   logic              sr_mode = 1'b0;
   logic [1:0]        ul = 2'h0;
   logic [15:0]       last = 16'h0000;
   logic              susp = 1'b0;
   logic              wb = 1'b0;
   // overlays and nv register array are never entered here
   logic              rd_on;
   logic [15:0]       rd_word;
   logic              a555;
   assign rd_on = !fl_ce_n && !fl_oe_n && !fl_dq_oe;
   assign rd_word = sr_mode ? sr_q : (fl_addr[15:0] ^ 16'ha5a5);
   // a released bus shows the inverse of the last word
   assign fl_dq_in = rd_on ? rd_word : ~last;
   assign a555 = fl_addr == ADDR_W'(`FCD_A_UNLOCK1);
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge fl_oe_n) begin
      last = rd_word;
      sr_mode = 1'b0;
   end
   always @(posedge fl_we_n) begin
      if (fl_ce_n === 1'b0) begin
         if (n_wr < 64) begin
            wa[n_wr] = fl_addr;
            wd[n_wr] = fl_dq_out;
         end
         n_wr++;
         if (fl_dq_out == 16'h00f0) begin
            ul = 2'h0;
            wb = 1'b0;
            sr_mode = 1'b0;
         end else if (wb)
            wb = fl_dq_out != 16'h0029;
         else if (ul == 2'h1)
            ul = (fl_addr == ADDR_W'(`FCD_A_UNLOCK2) && fl_dq_out == 16'h0055) ? 2'h2 : 2'h0;
         else if (ul == 2'h2) begin
            ul = 2'h0;
            wb = fl_dq_out == 16'h0025;
         end else if (fl_dq_out == 16'h00b0)
            susp = 1'b1;
         else if (susp && fl_dq_out == 16'h0030)
            susp = 1'b0;
         else if (a555 && fl_dq_out == 16'h00aa)
            ul = 2'h1;
         else if (a555 && fl_dq_out == 16'h0070)
            sr_mode = 1'b1;
         else if (a555 && fl_dq_out == 16'h0071)
            sr_q = sr_q & 16'hffcf;
      end
   end
endmodule // fcd_flash_model

//--- tb/fcd_host_sva.sv
// port assertions of the flash command sequencer
`timescale 1ns/10ps
module fcd_host_sva #(
   parameter int ADDR_W = 26
) (
   input wire logic              ref_clk,
   input wire logic              arst_n,
   input wire logic              cmd_valid,
   input wire fcd_pkg::fcd_op_e  cmd_op,
   input wire logic              cmd_ready,
   input wire logic              cmd_done,
   input wire logic              buf_ready,
   input wire logic              rd_valid,
   input wire logic [ADDR_W-1:0] fl_addr,
   input wire logic [15:0]       fl_dq_out,
   input wire logic              fl_dq_oe,
   input wire logic              fl_ce_n,
   input wire logic              fl_we_n,
   input wire logic              fl_oe_n
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);
   logic take;
   assign take = cmd_valid && cmd_ready;
   ////////////////////////////////////////////////////////////////////////////////
   a_we_qualified: assert property (!fl_we_n |-> !fl_ce_n && fl_dq_oe && fl_oe_n)
      else $error("write strobe without select, data or with read");
   a_we_width: assert property ($fell(fl_we_n) |-> !fl_we_n [*7] ##1 fl_we_n)
      else $error("write pulse not seven cycles");
   a_wr_stable: assert property (!fl_we_n |-> $stable(fl_addr) && $stable(fl_dq_out))
      else $error("address or data moved under write strobe");
   a_reset_len: assert property (take && cmd_op == fcd_pkg::FCD_OP_RESET |-> ##15 cmd_done)
      else $error("single write command not done in 15 cycles");
   a_clear_len: assert property (take && cmd_op == fcd_pkg::FCD_OP_SR_CLEAR |-> ##15 cmd_done)
      else $error("status clear not done in 15 cycles");
   a_susp_len: assert property (take && cmd_op == fcd_pkg::FCD_OP_SUSPEND |-> ##15 cmd_done)
      else $error("suspend not done in 15 cycles");
   a_ready_cycle: assert property (take |=> !cmd_ready until_with cmd_done)
      else $error("ready while a sequence runs");
   a_done_pulse: assert property (cmd_done |=> !cmd_done && cmd_ready)
      else $error("done not a pulse or ready not back");
   a_read_excl: assert property (!fl_oe_n |-> fl_we_n && !fl_dq_oe && !fl_ce_n)
      else $error("read cycle overlaps a write");
   a_rd_valid: assert property ($rose(fl_oe_n) |-> rd_valid)
      else $error("no read valid after read cycle");
   a_buf_pulse: assert property (buf_ready |=> !buf_ready)
      else $error("buffer ready longer than a cycle");
   c_buf: cover property (take && cmd_op == fcd_pkg::FCD_OP_BUF_PROG);
   c_pair: cover property (buf_ready);
   c_read: cover property (rd_valid);
endmodule // fcd_host_sva

//--- tb/test_fcd_host.sv
// self-checking bench of the flash command sequencer
`timescale 1ns/10ps
module test_fcd_host;
   localparam int AW = 26;
   localparam logic [AW-1:0] sector_address = 26'h0012000;
   logic             ref_clk = 1'b0;
   logic             arst_n = 1'b0;
   logic             cmd_valid = 1'b0;
   fcd_pkg::fcd_op_e cmd_op = fcd_pkg::FCD_OP_READ;
   logic [AW-1:0]    cmd_addr = '0;
   logic [15:0]      cmd_data = 16'h0000;
   logic [7:0]       cmd_count = 8'h00;
   logic             buf_valid = 1'b0;
   logic [AW-1:0]    buf_loc = '0;
   logic [15:0]      buf_data = 16'h0000;
   logic             cmd_ready, cmd_done, buf_ready, rd_valid, fl_dq_oe;
   logic             fl_ce_n, fl_we_n, fl_oe_n;
   logic [15:0]      rd_data, fl_dq_out, fl_dq_in;
   logic [AW-1:0]    fl_addr;
   int               n_fail = 0;
   int               tests_run = 0;
   int               ptr = 0;
   int               cyc = 0;
   fcd_host #(.ADDR_W(AW)) uut (.ref_clk(ref_clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_count(cmd_count),
      .cmd_ready(cmd_ready), .cmd_done(cmd_done), .buf_valid(buf_valid), .buf_loc(buf_loc),
      .buf_data(buf_data), .buf_ready(buf_ready), .rd_data(rd_data), .rd_valid(rd_valid),
      .fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_dq_in(fl_dq_in),
      .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n));
   fcd_flash_model #(.ADDR_W(AW)) mdl (.fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
      .fl_dq_oe(fl_dq_oe), .fl_dq_in(fl_dq_in), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
      .fl_oe_n(fl_oe_n));
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         $display("CHECK FAILED %0t timeout", $time);
         finish_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      if (n_fail == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic bad(input string msg);
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, msg);
   endtask
   task automatic chk_wr(input logic [AW-1:0] a, input logic [15:0] d);
      tests_run++;
      if (ptr >= mdl.n_wr || mdl.wa[ptr] !== a || mdl.wd[ptr] !== d)
         bad($sformatf("bus write %0d wrong", ptr));
      ptr++;
   endtask
   task automatic chk_rd(input logic [15:0] d);
      tests_run++;
      if (rd_data !== d)
         bad($sformatf("read %h expected %h", rd_data, d));
   endtask
   task automatic chk_bit(input logic v, input logic e, input string msg);
      tests_run++;
      if (v !== e)
         bad(msg);
   endtask
   task automatic unlock();
      chk_wr(26'h555, 16'h00aa);
      chk_wr(26'h2aa, 16'h0055);
   endtask
   task automatic run(input fcd_pkg::fcd_op_e op, input logic [AW-1:0] a,
                      input logic [15:0] d, input logic [7:0] c);
      int k;
      k = 0;
      while (cmd_ready !== 1'b1 && k < 100) begin
         @(posedge ref_clk);
         #1 k++;
      end
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_addr = a;
      cmd_data = d;
      cmd_count = c;
      @(posedge ref_clk);
      #1 cmd_valid = 1'b0;
      k = 0;
      while (cmd_done !== 1'b1 && k < 600) begin
         @(posedge ref_clk);
         #1 k++;
      end
      if (k >= 600)
         bad("no done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      run(fcd_pkg::FCD_OP_RESET, 26'h0, 16'h0, 8'h0);
      chk_wr(26'h0, 16'h00f0);
      run(fcd_pkg::FCD_OP_READ, 26'h123, 16'h0, 8'h0);
      chk_rd(16'h0123 ^ 16'ha5a5);
   endtask
   task automatic t_status();
      run(fcd_pkg::FCD_OP_SR_READ, 26'h40, 16'h0, 8'h0);
      chk_wr(26'h555, 16'h0070);
      chk_rd(16'h00a0);
      run(fcd_pkg::FCD_OP_READ, 26'h40, 16'h0, 8'h0);
      chk_rd(16'h0040 ^ 16'ha5a5);
      run(fcd_pkg::FCD_OP_SR_CLEAR, 26'h0, 16'h0, 8'h0);
      chk_wr(26'h555, 16'h0071);
      run(fcd_pkg::FCD_OP_SR_READ, 26'h7, 16'h0, 8'h0);
      chk_wr(26'h555, 16'h0070);
      chk_rd(16'h0080);
   endtask
   task automatic t_word();
      run(fcd_pkg::FCD_OP_WORD_PROG, 26'h3ffffff, 16'hbeef, 8'h0);
      unlock();
      chk_wr(26'h555, 16'h00a0);
      chk_wr(26'h3ffffff, 16'hbeef);
   endtask
   task automatic t_buffer();
      int k;
      fork
         run(fcd_pkg::FCD_OP_BUF_PROG, sector_address, 16'h0, 8'h01);
         for (int i = 0; i < 2; i++) begin
            buf_valid = 1'b1;
            buf_loc = sector_address + AW'(i);
            buf_data = 16'h1111 * 16'(i + 1);
            k = 0;
            do begin
               @(posedge ref_clk);
               #1 k++;
            end while (buf_ready !== 1'b1 && k < 300);
            chk_bit(mdl.wb, 1'b1, "buffer load state lost");
         end
      join
      buf_valid = 1'b0;
      unlock();
      chk_wr(sector_address, 16'h0025);
      chk_wr(sector_address, 16'h0001);
      chk_wr(sector_address, 16'h1111);
      chk_wr(sector_address + 26'h1, 16'h2222);
      chk_wr(sector_address, 16'h0029);
      chk_bit(mdl.wb, 1'b0, "buffer state not left after confirm");
      run(fcd_pkg::FCD_OP_BUF_ABORT, 26'h0, 16'h0, 8'h0);
      unlock();
      chk_wr(26'h555, 16'h00f0);
   endtask
   task automatic t_erase();
      run(fcd_pkg::FCD_OP_CHIP_ERASE, 26'h0, 16'h0, 8'h0);
      unlock();
      chk_wr(26'h555, 16'h0080);
      unlock();
      chk_wr(26'h555, 16'h0010);
      run(fcd_pkg::FCD_OP_SECT_ERASE, sector_address, 16'h0, 8'h0);
      unlock();
      chk_wr(26'h555, 16'h0080);
      unlock();
      chk_wr(sector_address, 16'h0030);
   endtask
   task automatic t_suspend();
      run(fcd_pkg::FCD_OP_SUSPEND, 26'h0, 16'h0, 8'h0);
      chk_wr(26'h0, 16'h00b0);
      chk_bit(mdl.susp, 1'b1, "suspend not taken");
      run(fcd_pkg::FCD_OP_RESUME, 26'h0, 16'h0, 8'h0);
      chk_wr(26'h0, 16'h0030);
      chk_bit(mdl.susp, 1'b0, "resume not taken");
   endtask
   task automatic t_protect();
      run(fcd_pkg::FCD_OP_VPB_SET, sector_address, 16'h0, 8'h0);
      chk_wr(26'h0, 16'h00a0);
      chk_wr(sector_address, 16'h0000);
      run(fcd_pkg::FCD_OP_VPB_CLR, sector_address, 16'h0, 8'h0);
      chk_wr(26'h0, 16'h00a0);
      chk_wr(sector_address, 16'h0001);
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      #1 arst_n = 1'b1;
      t_reset();
      t_status();
      t_word();
      t_buffer();
      t_erase();
      t_suspend();
      t_protect();
      finish_test();
   end
endmodule // test_fcd_host
bind fcd_host fcd_host_sva #(.ADDR_W(ADDR_W)) u_sva (.ref_clk(ref_clk), .arst_n(arst_n),
   .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
   .buf_ready(buf_ready), .rd_valid(rd_valid), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
   .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n));
